// ==== bench/camac_block_transfer_lam_test.sv ====
`timescale 1ns/10ps
module camac_block_transfer_lam_test
  import cbt_pkg::*;
;
  logic         clock, arst_n, go, z_in, busy, rx, rq, x_resp, q_resp, lam, hold_p2;
  logic         tag_instruction, routine_end, reg_wr, reg_rd;
  logic [3:0]   tag_number, reg_addr;
  logic [15:0]  internal_bus, wdata, rdata, r_lines, write_word, reg_wdata, reg_rdata;
  cbt_naf_t     naf;
  cbt_dataway_t dw_in;
  cbt_flags_t   flags;
  int           num_errors = 0, num_checks = 0, cycles = 0;
  cbt_unit dut (
    .clock(clock), .arst_n(arst_n), .dw_in(dw_in), .r_lines(r_lines), .q_resp(q_resp),
    .x_resp(x_resp), .lam(lam), .hold_p2(hold_p2), .internal_bus(internal_bus),
    .tag_instruction(tag_instruction), .tag_number(tag_number), .flags(flags),
    .routine_end(routine_end), .write_word(write_word), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata)
  );
  cbt_crate_model crate (
    .clock(clock), .arst_n(arst_n), .go(go), .naf(naf), .wdata(wdata), .z_in(z_in),
    .busy(busy), .rdata(rdata), .rx(rx), .rq(rq), .hold_p2(hold_p2), .r_lines(r_lines),
    .x_resp(x_resp), .q_resp(q_resp), .dw(dw_in)
  );
  // ----
  // helpers
  // ----
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      num_errors = num_errors + 1;
      test_done();
    end
  end
  task automatic test_done();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : test_done
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic reg_write(input logic [3:0] a, input logic [15:0] d);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask : reg_write
  task automatic reg_read(input logic [3:0] a, input logic [15:0] e);
    @(posedge clock);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, e);
  endtask : reg_read
  task automatic send(input logic [3:0] a, input logic [4:0] f, input logic [15:0] w);
    @(posedge clock);
    go <= 1'b1;
    naf <= '{1'b1, a, f};
    wdata <= w;
    @(posedge clock);
    go <= 1'b0;
    #1;
  endtask : send
  task automatic wait_done();
    while (busy) begin
      @(posedge clock);
      #1;
    end
  endtask : wait_done
  task automatic cyc(input logic [3:0] a, input logic [4:0] f);
    send(a, f, 16'hc3a5);
    wait_done();
  endtask : cyc
  task automatic pulse(input logic end_n, input logic [3:0] num);
    @(posedge clock);
    tag_instruction <= end_n;
    tag_number <= num;
    routine_end <= !end_n;
    @(posedge clock);
    tag_instruction <= 1'b0;
    routine_end <= 1'b0;
    #1;
  endtask : pulse
  // ----
  // scenarios
  // ----
  task automatic t_regs();
    reg_read(OFF_CTRL, CTRL_RESET);
    reg_read(OFF_STATUS, 16'h0020);
    reg_read(4'hf, 16'h0000);
    reg_write(OFF_CTRL, 16'hfffe);
    reg_read(OFF_CTRL, 16'h0000);
    cyc(SA_BLOCK, FN_READ);
    chk(rx, 1'b0);
    reg_write(OFF_CTRL, 16'hffff);
    reg_read(OFF_CTRL, 16'h0001);
  endtask : t_regs
  task automatic t_read();
    @(posedge clock);
    internal_bus <= 16'h5a3c;
    cyc(SA_BLOCK, FN_READ);
    chk(rdata, 16'h5a3c);
    chk(flags.flag_read, 1'b1);
    chk(rx, 1'b1);
  endtask : t_read
  task automatic t_q();
    pulse(1'b1, TAG_Q_SET);
    cyc(SA_BLOCK, FN_READ);
    chk(rq, 1'b1);
    cyc(SA_BLOCK, FN_DISABLE);
    chk(rx, 1'b1);
    cyc(SA_BLOCK, FN_READ);
    chk(rq, 1'b0);
    pulse(1'b1, TAG_Q_SET);
    z_in <= 1'b1;
    repeat (4) @(posedge clock);
    z_in <= 1'b0;
    cyc(SA_BLOCK, FN_READ);
    chk(rq, 1'b0);
  endtask : t_q
  task automatic t_hold();
    @(posedge clock);
    internal_bus <= 16'h1234;
    send(SA_BLOCK_HOLD, FN_READ, 16'h0000);
    repeat (3) @(posedge clock);
    #1;
    chk(hold_p2, 1'b1);
    chk(flags.flag_hold, 1'b1);
    pulse(1'b0, 4'h0);
    chk(hold_p2, 1'b0);
    chk(flags.flag_hold, 1'b0);
    wait_done();
    chk(rdata, 16'h1234);
    chk(flags.flag_hold, 1'b1);
    pulse(1'b0, 4'h0);
    chk(flags.flag_hold, 1'b0);
  endtask : t_hold
  task automatic t_write();
    cyc(SA_BLOCK, FN_WRITE);
    chk(write_word, 16'hc3a5);
    chk(flags.flag_write, 1'b1);
    reg_read(OFF_WR_WORD, 16'hc3a5);
    reg_read(OFF_RD_WORD, 16'h1234);
  endtask : t_write
  task automatic t_lam();
    pulse(1'b1, TAG_LAM_SET);
    cyc(SA_LAM, FN_TEST_LAM);
    chk(rq, 1'b1);
    cyc(SA_LAM, FN_ENABLE);
    chk(lam, 1'b1);
    cyc(SA_LAM, FN_DISABLE);
    chk(lam, 1'b0);
    cyc(SA_LAM, FN_CLR_LAM);
    cyc(SA_LAM, FN_TEST_LAM);
    chk(rq, 1'b0);
    pulse(1'b1, TAG_LAM_SET);
    z_in <= 1'b1;
    cyc(4'h3, FN_READ);
    z_in <= 1'b0;
    cyc(SA_LAM, FN_TEST_LAM);
    chk(rq, 1'b0);
  endtask : t_lam
  initial begin
    {go, z_in, tag_instruction, routine_end, reg_wr, reg_rd} = '0;
    {naf, wdata, tag_number, reg_addr, reg_wdata, internal_bus} = '0;
    arst_n = 1'b0;
    repeat (5) @(posedge clock);
    arst_n <= 1'b1;
    t_regs();
    t_read();
    t_q();
    t_hold();
    t_write();
    t_lam();
    test_done();
  end
endmodule : camac_block_transfer_lam_test

// ==== bench/cbt_crate_model.sv ====
`timescale 1ns/10ps
module cbt_crate_model
  import cbt_pkg::*;
(
  // clock and reset
  input wire logic         clock,
  input wire logic         arst_n,
  // bench side
  input wire logic         go,
  input wire cbt_naf_t     naf,
  input wire logic [15:0]  wdata,
  input wire logic         z_in,
  output logic             busy,
  output logic [15:0]      rdata,
  output logic             rx,
  output logic             rq,
  // dataway
  input wire logic         hold_p2,
  input wire logic [15:0]  r_lines,
  input wire logic         x_resp,
  input wire logic         q_resp,
  output cbt_dataway_t     dw
);
  cbt_naf_t    naf_reg;
  logic        s1_reg;
  logic        s2_reg;
  logic [15:0] w_reg;
  assign dw = {naf_reg, s1_reg, s2_reg, z_in, w_reg};
  initial begin
    {naf_reg, s1_reg, s2_reg, busy, rdata, rx, rq, w_reg} = '0;
    forever begin
      @(posedge clock);
      if (go && arst_n) begin
        busy <= 1'b1;
        naf_reg <= naf;
        w_reg <= (naf.f == FN_WRITE) ? wdata : ~w_reg;
        repeat (6) @(posedge clock);
        while (hold_p2) @(posedge clock);
        s1_reg <= 1'b1;
        rdata <= r_lines;
        rx <= x_resp;
        rq <= q_resp;
        repeat (4) @(posedge clock);
        s1_reg <= 1'b0;
        repeat (2) @(posedge clock);
        s2_reg <= 1'b1;
        repeat (4) @(posedge clock);
        s2_reg <= 1'b0;
        repeat (2) @(posedge clock);
        naf_reg <= '0;
        w_reg <= ~w_reg;
        busy <= 1'b0;
      end
    end
  end
endmodule : cbt_crate_model

// ==== bench/cbt_unit_monitor.sv ====
`timescale 1ns/10ps
module cbt_monitor
  import cbt_pkg::*;
(
  // clock and reset
  input wire logic         clock,
  input wire logic         arst_n,
  // watched ports
  input wire cbt_dataway_t dw_in,
  input wire logic [15:0]  r_lines,
  input wire logic         x_resp,
  input wire logic         hold_p2,
  input wire logic [15:0]  internal_bus,
  input wire logic         routine_end,
  input wire cbt_flags_t   flags,
  input wire logic         reg_rd,
  input wire logic [15:0]  reg_rdata
);
  // ----
  // pulse counters
  // ----
  logic [7:0] rd_cnt_reg;
  logic [7:0] wr_cnt_reg;
  logic       quiet;
  assign quiet = !dw_in.s2 && !dw_in.z;
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rd_cnt_reg <= 8'h00;
      wr_cnt_reg <= 8'h00;
    end else begin
      rd_cnt_reg <= flags.flag_read ? rd_cnt_reg + 8'h01 : 8'h00;
      wr_cnt_reg <= flags.flag_write ? wr_cnt_reg + 8'h01 : 8'h00;
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);
  a_read_width:
    assert property ($fell(flags.flag_read) |-> rd_cnt_reg == 8'(FLAG_PULSE_CYC))
    else $error("read flag width wrong");
  a_write_width:
    assert property ($fell(flags.flag_write) |-> wr_cnt_reg == 8'(FLAG_PULSE_CYC))
    else $error("write flag width wrong");
  a_x_cmd:
    assert property (x_resp |-> $past(dw_in.naf.n, 3)) else $error("x without station");
  a_hold_cmd:
    assert property (hold_p2 |-> $past(dw_in.naf, 2) == {1'b1, SA_BLOCK_HOLD, FN_READ})
    else $error("hold without command");
  a_hold_flag:
    assert property ($rose(hold_p2) |-> ##[0:1] flags.flag_hold) else $error("no flag");
  a_hold_release:
    assert property (routine_end && $past(quiet, 1) && $past(quiet, 2) && $past(quiet, 3)
      |=> !hold_p2 && !flags.flag_hold) else $error("hold not released");
  a_rdata_idle:
    assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000) else $error("rdata not 0");
  a_rlines_bus:
    assert property (r_lines != 16'h0000 |-> r_lines == $past(internal_bus) && x_resp)
    else $error("r lines wrong");
endmodule : cbt_monitor
bind cbt_unit cbt_monitor u_monitor (
  .clock(clock), .arst_n(arst_n), .dw_in(dw_in), .r_lines(r_lines), .x_resp(x_resp),
  .hold_p2(hold_p2), .internal_bus(internal_bus), .routine_end(routine_end),
  .flags(flags), .reg_rd(reg_rd), .reg_rdata(reg_rdata)
);

// ==== logic/cbt_flag_pulse.sv ====
`timescale 1ns/10ps
module cbt_flag_pulse
  import cbt_pkg::*;
(
  // clock and reset
  input  wire logic clock,
  input  wire logic arst_n,
  // trigger and pulse
  input  wire logic trig,
  output logic      pulse
);

  logic [7:0] cnt_reg;
  logic [7:0] cnt_next;

  // ----------------------------------------------------------------
  // fixed width pulse, retrigger ignored while running
  // ----------------------------------------------------------------
  assign cnt_next = (trig && cnt_reg == 8'h00) ? 8'(FLAG_PULSE_CYC) :
                    (cnt_reg != 8'h00)          ? cnt_reg - 8'h01  : 8'h00;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      cnt_reg <= 8'h00;
      pulse   <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      pulse   <= (cnt_next != 8'h00);
    end
  end

endmodule : cbt_flag_pulse

// ==== logic/cbt_pkg.sv ====
package cbt_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_MHZ        = 200;
  localparam int unsigned FLAG_PULSE_NS  = 250;
  localparam int unsigned FLAG_PULSE_CYC =
    (FLAG_PULSE_NS * CLK_MHZ) / 1000 < 1 ? 1 : (FLAG_PULSE_NS * CLK_MHZ) / 1000;
  localparam int unsigned SYNC_STAGES    = 2;

  // ----------------------------------------------------------------
  // dataway sub-addresses and function codes
  // ----------------------------------------------------------------
  localparam logic [3:0] SA_LAM        = 4'h0;
  localparam logic [3:0] SA_BLOCK      = 4'h7;
  localparam logic [3:0] SA_BLOCK_HOLD = 4'h8;
  localparam logic [4:0] FN_READ       = 5'h01;
  localparam logic [4:0] FN_CLR_LAM    = 5'h0a;
  localparam logic [4:0] FN_WRITE      = 5'h10;
  localparam logic [4:0] FN_DISABLE    = 5'h18;
  localparam logic [4:0] FN_ENABLE     = 5'h1a;
  localparam logic [4:0] FN_TEST_LAM   = 5'h1b;

  // ----------------------------------------------------------------
  // processor tag numbers
  // ----------------------------------------------------------------
  localparam logic [3:0] TAG_Q_SET     = 4'h1;
  localparam logic [3:0] TAG_LAM_SET   = 4'h2;

  // ----------------------------------------------------------------
  // register map, fields and reset values
  // ----------------------------------------------------------------
  localparam logic [3:0] OFF_CTRL      = 4'h0;
  localparam logic [3:0] OFF_STATUS    = 4'h1;
  localparam logic [3:0] OFF_RD_WORD   = 4'h2;
  localparam logic [3:0] OFF_WR_WORD   = 4'h3;
  localparam int unsigned CTRL_EN_BIT  = 0;
  localparam logic [15:0] CTRL_RESET   = 16'h0001;
  localparam logic        HOLD_EN_RESET = 1'b1;
  localparam int unsigned ST_Q_BIT     = 0;
  localparam int unsigned ST_LSTAT_BIT = 1;
  localparam int unsigned ST_LMASK_BIT = 2;
  localparam int unsigned ST_HOLD_BIT  = 3;
  localparam int unsigned ST_FREQ_BIT  = 4;
  localparam int unsigned ST_HEN_BIT   = 5;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        n;
    logic [3:0]  a;
    logic [4:0]  f;
  } cbt_naf_t;

  typedef struct packed {
    cbt_naf_t    naf;
    logic        s1;
    logic        s2;
    logic        z;
    logic [15:0] w;
  } cbt_dataway_t;

  typedef struct packed {
    logic        flag_read;
    logic        flag_write;
    logic        flag_hold;
  } cbt_flags_t;

endpackage : cbt_pkg

// ==== logic/cbt_unit.sv ====
// Functional notes
// (R1) block read A7 F1 enables readout gates and flags the processor read routine
// (R2) block transfer flag is one pulse about 250 ns wide
// (R3) processor keeps read word stable until S2 begins
// (R4) processor sets Q at start, clears it after the last word; here only A7 F24 and Z clear Q, no processor clear path
// (R5) Q flip-flop cleared by A7 F24 and by Z
// (R6) A8 F1 raises HOLD on P2 at once, stopping S1 and S2
// (R7) A8 F1 also sets the flag request flip-flop
// (R8) routine end resets hold enable and flag request; HOLD then drops
// (R9) after HOLD falls, data read at S1; hold enable set again at S2
// (R10) command still present at S2 re-sets flag request; routine once per cycle
// (R11) block write A7 F16 raises a flag; routine stores the write word
// (R12) A0 F26 enables LAM mask, F24 disables, F27 tests status as Q
// (R13) LAM status cleared by A0 F10 and by Z with S2
// (R14) tag instruction with the wired number sets LAM status
// (R15) tag number 1 sets Q flip-flop, held through the block
// (R16) hold flag line is flag 6, wired to a chosen processor input
// (R17) initiating routine loads address, count, and prefetches first read word
// (R18) read routine runs one word ahead of the dataway
// (R19) flag poll routine checks flags each micro-cycle, returns to location 0
// (R20) X asserted for every decoded block, Q-clear and LAM function
`timescale 1ns/10ps
module cbt_unit
  import cbt_pkg::*;
#(
  parameter logic [3:0] LAM_TAG = TAG_LAM_SET
) (
  // clock and reset
  input  wire logic         clock,
  input  wire logic         arst_n,
  // dataway inputs
  input  wire cbt_dataway_t dw_in,
  // dataway outputs
  output logic [15:0]       r_lines,
  output logic              q_resp,
  output logic              x_resp,
  output logic              lam,
  output logic              hold_p2,
  // processor side
  input  wire logic [15:0]  internal_bus,
  input  wire logic         tag_instruction,
  input  wire logic [3:0]   tag_number,
  input  wire logic         routine_end,
  output cbt_flags_t        flags,
  output logic [15:0]       write_word,
  // register port
  input  wire logic [3:0]   reg_addr,
  input  wire logic [15:0]  reg_wdata,
  input  wire logic         reg_wr,
  input  wire logic         reg_rd,
  output logic [15:0]       reg_rdata
);

  // ----------------------------------------------------------------
  // dataway synchronisers
  // ----------------------------------------------------------------
  localparam int unsigned DW_W = $bits(cbt_dataway_t);

  logic [DW_W-1:0] sync1_reg;
  logic [DW_W-1:0] sync2_reg;
  cbt_dataway_t    dw;
  logic            s1_d_reg;
  logic            s2_d_reg;

  genvar gi;
  generate
    for (gi = 0; gi < DW_W; gi++) begin : g_sync
      always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
          sync1_reg[gi] <= 1'b0;
          sync2_reg[gi] <= 1'b0;
        end else begin
          sync1_reg[gi] <= dw_in[gi];
          sync2_reg[gi] <= sync1_reg[gi];
        end
      end
    end
  endgenerate

  assign dw = cbt_dataway_t'(sync2_reg);

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      s1_d_reg <= 1'b0;
      s2_d_reg <= 1'b0;
    end else begin
      s1_d_reg <= dw.s1;
      s2_d_reg <= dw.s2;
    end
  end

  // ----------------------------------------------------------------
  // strobes and function decode
  // ----------------------------------------------------------------
  logic        ctrl_reg;
  logic        s1_rise;
  logic        s2_rise;
  logic        zs2;
  logic        sel;
  logic        dec_rd;
  logic        dec_rdh;
  logic        dec_wr;
  logic        dec_qclr;
  logic        dec_lmen;
  logic        dec_lmdis;
  logic        dec_ltest;
  logic        dec_lclr;
  logic        dec_any;

  assign s1_rise   = dw.s1 && !s1_d_reg;
  assign s2_rise   = dw.s2 && !s2_d_reg;
  assign zs2       = dw.z && dw.s2;
  assign sel       = dw.naf.n && ctrl_reg;
  assign dec_rd    = sel && dw.naf.a == SA_BLOCK && dw.naf.f == FN_READ;
  assign dec_rdh   = sel && dw.naf.a == SA_BLOCK_HOLD && dw.naf.f == FN_READ;
  assign dec_wr    = sel && dw.naf.a == SA_BLOCK && dw.naf.f == FN_WRITE;
  assign dec_qclr  = sel && dw.naf.a == SA_BLOCK && dw.naf.f == FN_DISABLE;
  assign dec_lmen  = sel && dw.naf.a == SA_LAM && dw.naf.f == FN_ENABLE;
  assign dec_lmdis = sel && dw.naf.a == SA_LAM && dw.naf.f == FN_DISABLE;
  assign dec_ltest = sel && dw.naf.a == SA_LAM && dw.naf.f == FN_TEST_LAM;
  assign dec_lclr  = sel && dw.naf.a == SA_LAM && dw.naf.f == FN_CLR_LAM;
  assign dec_any   = dec_rd || dec_rdh || dec_wr || dec_qclr
                   || dec_lmen || dec_lmdis || dec_ltest || dec_lclr;

  // ----------------------------------------------------------------
  // q flip-flop
  // ----------------------------------------------------------------
  logic q_response_ff;
  logic q_next;
  logic q_set;
  logic q_clr;

  assign q_set  = tag_instruction && tag_number == TAG_Q_SET;  // [R15] [R4]
  assign q_clr  = (dec_qclr && s1_rise) || dw.z;  // [R5]
  // set wins over a simultaneous clear
  assign q_next = q_set ? 1'b1 : q_clr ? 1'b0 : q_response_ff;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      q_response_ff <= 1'b0;
    end else begin
      q_response_ff <= q_next;
    end
  end

  // ----------------------------------------------------------------
  // hold edge, flag request fires once per hold
  // ----------------------------------------------------------------
  logic hold_d_reg;
  logic hold_rise;

  assign hold_rise = hold_p2 && !hold_d_reg;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      hold_d_reg <= 1'b0;
    end else begin
      hold_d_reg <= hold_p2;
    end
  end

  // ----------------------------------------------------------------
  // hold and flag request
  // ----------------------------------------------------------------
  logic hold_enable_ff;
  logic flag_request_ff;
  logic hen_next;
  logic freq_next;
  logic freq_set;

  assign hold_p2   = dec_rdh && hold_enable_ff;  // [R6] [R8]
  assign freq_set  = hold_rise;  // [R7] [R10]
  // flag request set beats routine-end clear
  assign freq_next = freq_set ? 1'b1
                   : (routine_end || dw.z) ? 1'b0 : flag_request_ff;  // [R8]
  // re-armed at s2 after the hold has dropped
  assign hen_next  = (s2_rise || dw.z) ? 1'b1  // [R9]
                   : routine_end ? 1'b0 : hold_enable_ff;  // [R8]

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      hold_enable_ff  <= HOLD_EN_RESET;
      flag_request_ff <= 1'b0;
    end else begin
      hold_enable_ff  <= hen_next;
      flag_request_ff <= freq_next;
    end
  end

  // ----------------------------------------------------------------
  // lam status and mask
  // ----------------------------------------------------------------
  logic lam_status_reg;
  logic lam_mask_reg;
  logic lstat_next;
  logic lmask_next;
  logic lstat_set;

  assign lstat_set  = tag_instruction && tag_number == LAM_TAG;  // [R14]
  assign lstat_next = lstat_set ? 1'b1
                    : ((dec_lclr && s1_rise) || zs2) ? 1'b0  // [R13]
                    : lam_status_reg;
  assign lmask_next = (dec_lmen && s1_rise) ? 1'b1  // [R12]
                    : ((dec_lmdis && s1_rise) || zs2) ? 1'b0  // [R12]
                    : lam_mask_reg;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      lam_status_reg <= 1'b0;
      lam_mask_reg   <= 1'b0;
    end else begin
      lam_status_reg <= lstat_next;
      lam_mask_reg   <= lmask_next;
    end
  end

  // ----------------------------------------------------------------
  // flag pulses to the processor
  // ----------------------------------------------------------------
  logic flag_rd_pulse;
  logic flag_wr_pulse;

  cbt_flag_pulse u_flag_rd (
    .clock  (clock),
    .arst_n (arst_n),
    .trig   (dec_rd && s1_rise),  // [R1] [R18]
    .pulse  (flag_rd_pulse)  // [R2]
  );

  cbt_flag_pulse u_flag_wr (
    .clock  (clock),
    .arst_n (arst_n),
    .trig   (dec_wr && s1_rise),  // [R11]
    .pulse  (flag_wr_pulse)  // [R2]
  );

  assign flags.flag_read  = flag_rd_pulse;
  assign flags.flag_write = flag_wr_pulse;
  assign flags.flag_hold  = flag_request_ff;  // [R16] [R19]

  // ----------------------------------------------------------------
  // dataway responses and data paths
  // ----------------------------------------------------------------
  logic        rd_gate;
  logic        q_sel;
  logic [15:0] write_word_reg;

  // prefetched word waits on the internal bus
  assign rd_gate = dec_rd || dec_rdh;  // [R1] [R3] [R17]
  assign q_sel   = dec_ltest ? lam_status_reg : q_response_ff;  // [R12]

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      r_lines        <= 16'h0000;
      q_resp         <= 1'b0;
      x_resp         <= 1'b0;
      lam            <= 1'b0;
      write_word_reg <= 16'h0000;
    end else begin
      r_lines <= rd_gate ? internal_bus : 16'h0000;  // [R1]
      q_resp  <= dec_any && q_sel;
      x_resp  <= dec_any;  // [R20]
      lam     <= lam_status_reg && lam_mask_reg;
      if (dec_wr && s1_rise) begin
        write_word_reg <= dw.w;  // [R11]
      end
    end
  end

  assign write_word = write_word_reg;

  // ----------------------------------------------------------------
  // register port
  // ----------------------------------------------------------------
  logic [15:0] status_word;
  logic [15:0] rd_mux;

  assign status_word = 16'(
      (32'(q_response_ff)   << ST_Q_BIT)
    | (32'(lam_status_reg)  << ST_LSTAT_BIT)
    | (32'(lam_mask_reg)    << ST_LMASK_BIT)
    | (32'(hold_p2)         << ST_HOLD_BIT)
    | (32'(flag_request_ff) << ST_FREQ_BIT)
    | (32'(hold_enable_ff)  << ST_HEN_BIT));

  assign rd_mux = (reg_addr == OFF_CTRL)    ? {15'h0000, ctrl_reg} :
                  (reg_addr == OFF_STATUS)  ? status_word :
                  (reg_addr == OFF_RD_WORD) ? internal_bus :
                  (reg_addr == OFF_WR_WORD) ? write_word_reg : 16'h0000;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_reg  <= CTRL_RESET[CTRL_EN_BIT];
      reg_rdata <= 16'h0000;
    end else begin
      if (reg_wr && reg_addr == OFF_CTRL) begin
        ctrl_reg <= reg_wdata[CTRL_EN_BIT];
      end
      reg_rdata <= reg_rd ? rd_mux : 16'h0000;
    end
  end

endmodule : cbt_unit
